// File: inc/ios_pkg.sv
// constants, register layout and state types for the low i/o register space decoder
package ios_pkg;

    // address spaces
    localparam int         IOS_NREG      = 32;
    localparam logic [5:0] IOS_BIT_TOP   = 6'h1f;    // last bit-accessible i/o address
    localparam logic [7:0] IOS_DS_OFFSET = 8'h20;    // data-space alias offset
    localparam logic [7:0] IOS_DS_TOP    = 8'h5f;    // last data-space alias of i/o space
    localparam logic [7:0] IOS_RST_VAL   = 8'h00;    // value of every register after reset

    // register offsets (i/o address)
    localparam logic [4:0] IOS_OFS_COMPARATOR_INPUT_DIGITAL_DISABLE = 5'h01;
    localparam logic [4:0] IOS_OFS_SERIAL_BAUD_DIVISOR_HIGH         = 5'h02;
    localparam logic [4:0] IOS_OFS_SERIAL_FRAME_CONTROL             = 5'h03;
    localparam logic [4:0] IOS_OFS_COMPARATOR_CONTROL_STATUS        = 5'h08;
    localparam logic [4:0] IOS_OFS_SERIAL_BAUD_DIVISOR_LOW          = 5'h09;
    localparam logic [4:0] IOS_OFS_SERIAL_ENABLE_CONTROL            = 5'h0a;
    localparam logic [4:0] IOS_OFS_SERIAL_LINE_STATUS               = 5'h0b;
    localparam logic [4:0] IOS_OFS_SERIAL_DATA_BUFFER               = 5'h0c;
    localparam logic [4:0] IOS_OFS_UNIVERSAL_SERIAL_STATUS          = 5'h0e;
    localparam logic [4:0] IOS_OFS_UNIVERSAL_SERIAL_SHIFT_DATA      = 5'h0f;
    localparam logic [4:0] IOS_OFS_PORT_D_PIN_INPUT                 = 5'h10;
    localparam logic [4:0] IOS_OFS_PORT_D_DIRECTION                 = 5'h11;
    localparam logic [4:0] IOS_OFS_PORT_D_OUTPUT                    = 5'h12;
    localparam logic [4:0] IOS_OFS_GENERAL_SCRATCH_ZERO             = 5'h13;
    localparam logic [4:0] IOS_OFS_GENERAL_SCRATCH_ONE              = 5'h14;
    localparam logic [4:0] IOS_OFS_GENERAL_SCRATCH_TWO              = 5'h15;
    localparam logic [4:0] IOS_OFS_PORT_B_PIN_INPUT                 = 5'h16;
    localparam logic [4:0] IOS_OFS_PORT_B_DIRECTION                 = 5'h17;
    localparam logic [4:0] IOS_OFS_PORT_B_OUTPUT                    = 5'h18;
    localparam logic [4:0] IOS_OFS_PORT_A_PIN_INPUT                 = 5'h19;

    // field positions of hardware-set flags
    localparam int IOS_CMP_FLAG_BIT  = 4;
    localparam int IOS_TX_DONE_BIT   = 6;
    localparam int IOS_USI_START_BIT = 7;
    localparam int IOS_USI_OVF_BIT   = 6;
    localparam int IOS_USI_STOP_BIT  = 5;

    // one bit per i/o address 0x00..0x1f that holds a register
    localparam logic [31:0] IOS_IMPL = 32'h03ff_df0e;

    // bits software writes plainly, index = i/o address
    localparam logic [7:0] IOS_WR_MASK [IOS_NREG] = '{
        8'h00, 8'h03, 8'h0f, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hcf, 8'hff, 8'hfd, 8'h03, 8'hff, 8'h00, 8'h0f, 8'hff,
        8'h00, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
        8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // status flags cleared by writing one
    localparam logic [7:0] IOS_W1C_MASK [IOS_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h10, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'he0, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // read-only bits that show live hardware state
    localparam logic [7:0] IOS_HW_MASK [IOS_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h20, 8'h00, 8'h02, 8'hbc, 8'h00, 8'h00, 8'h10, 8'h00,
        8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
        8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // register file plus registered answers
    typedef struct packed {
        logic [IOS_NREG-1:0][7:0] regs;
        logic [7:0]               rdata;
        logic                     rvalid;
        logic                     skip;
        logic                     tvalid;
        logic                     tx_load;
    } ios_state_s;

    // pin synchroniser state
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] q;
    } ios_sync_s;

endpackage

// File: logic/ios_decoder.sv
// low i/o register space: byte, data-space alias and single-bit access
`timescale 1ns/10ps
// Summary of operation
// - addresses 0x00 to 0x1F accept single-bit set and clear.
// - one bit of 0x00 to 0x1F can be tested to skip on one or zero.
// - some status flags clear on a written one; a written zero keeps them.
// - single-bit set or clear changes only the addressed bit.
// - single-bit operations above 0x1F are refused.
// - in and out transfers use i/o addresses 0x00 to 0x3F.
// - each i/o register also appears in data space at address plus 0x20.
module ios_decoder
    import ios_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // i/o-space transfers
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [5:0]  io_addr,
    // data-space load and store
    input  wire logic        data_space_load,
    input  wire logic        data_space_store,
    input  wire logic [7:0]  ds_addr,
    // single-bit operations, addressed by io_addr
    input  wire logic        set_single_io_bit,
    input  wire logic        clear_single_io_bit,
    input  wire logic        skip_if_io_bit_one,
    input  wire logic        skip_if_io_bit_zero,
    input  wire logic [2:0]  bit_sel,
    // write data and answers
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic             skip_next,
    output logic             test_valid,
    // peripheral status and events
    input  wire logic        comparator_output,
    input  wire logic        comparator_flag_event,
    input  wire logic [7:0]  serial_status_in,
    input  wire logic        serial_rx_bit8,
    input  wire logic        serial_tx_done_event,
    input  wire logic        usi_collision,
    input  wire logic        usi_start_event,
    input  wire logic        usi_overflow_event,
    input  wire logic        usi_stop_event,
    // port pins
    input  wire logic [7:0]  pin_a_in,
    input  wire logic [7:0]  pin_b_in,
    input  wire logic [7:0]  pin_d_in,
    // register images to the peripherals
    output logic      [7:0]  port_b_drive,
    output logic      [7:0]  port_b_dir,
    output logic      [7:0]  port_d_drive,
    output logic      [7:0]  port_d_dir,
    output logic      [7:0]  comparator_ctrl,
    output logic      [7:0]  comparator_dig_disable,
    output logic      [7:0]  serial_enable_ctrl,
    output logic      [7:0]  serial_frame_ctrl,
    output logic      [11:0] serial_baud_divisor,
    output logic      [7:0]  serial_tx_data,
    output logic             serial_tx_load,
    output logic      [7:0]  usi_shift_data,
    output logic      [7:0]  usi_status
);

    ios_state_s st_reg;
    ios_state_s st_next;

    logic [IOS_NREG-1:0][7:0] hw_val;
    logic [IOS_NREG-1:0][7:0] hw_set;
    logic [7:0] pin_a_q;
    logic [7:0] pin_b_q;
    logic [7:0] pin_d_q;
    logic [7:0] ds_ofs;
    logic       ds_in;
    logic       wr_go;
    logic       rd_go;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic       bit_go;
    logic [7:0] sel_mask;
    logic       hw_quiet;
    logic [7:0] test_byte;

    // pins arrive from outside the clock domain
    ios_pin_sync u_sync_a (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .pin_in (pin_a_in),
        .pin_q  (pin_a_q)
    );
    ios_pin_sync u_sync_b (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .pin_in (pin_b_in),
        .pin_q  (pin_b_q)
    );
    ios_pin_sync u_sync_d (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .pin_in (pin_d_in),
        .pin_q  (pin_d_q)
    );

    // live hardware bits and flag events, placed at their register slots
    always_comb begin
        hw_val = '0;
        hw_set = '0;
        hw_val[IOS_OFS_PORT_A_PIN_INPUT]          = pin_a_q;
        hw_val[IOS_OFS_PORT_B_PIN_INPUT]          = pin_b_q;
        hw_val[IOS_OFS_PORT_D_PIN_INPUT]          = pin_d_q;
        hw_val[IOS_OFS_COMPARATOR_CONTROL_STATUS] = {2'b00, comparator_output, 5'b0_0000};
        hw_val[IOS_OFS_SERIAL_LINE_STATUS]        = serial_status_in;
        hw_val[IOS_OFS_SERIAL_ENABLE_CONTROL]     = {6'b00_0000, serial_rx_bit8, 1'b0};
        hw_val[IOS_OFS_UNIVERSAL_SERIAL_STATUS]   = {3'b000, usi_collision, 4'h0};
        hw_set[IOS_OFS_COMPARATOR_CONTROL_STATUS][IOS_CMP_FLAG_BIT] = comparator_flag_event;
        hw_set[IOS_OFS_SERIAL_LINE_STATUS][IOS_TX_DONE_BIT]         = serial_tx_done_event;
        hw_set[IOS_OFS_UNIVERSAL_SERIAL_STATUS][IOS_USI_START_BIT]  = usi_start_event;
        hw_set[IOS_OFS_UNIVERSAL_SERIAL_STATUS][IOS_USI_OVF_BIT]    = usi_overflow_event;
        hw_set[IOS_OFS_UNIVERSAL_SERIAL_STATUS][IOS_USI_STOP_BIT]   = usi_stop_event;
    end

    assign hw_quiet = ~(comparator_flag_event | serial_tx_done_event | usi_start_event
                        | usi_overflow_event | usi_stop_event);

    // read view: stored bits plus live bits, zero for reserved bits and slots
    function automatic logic [7:0] rd_view(input logic [5:0] idx,
                                           input logic [IOS_NREG-1:0][7:0] regs,
                                           input logic [IOS_NREG-1:0][7:0] hv);
        logic [7:0] v;
        v = 8'h00;
        if (!idx[5] && IOS_IMPL[idx[4:0]]) begin
            v = (regs[idx[4:0]] & (IOS_WR_MASK[idx[4:0]] | IOS_W1C_MASK[idx[4:0]]))
                | (hv[idx[4:0]] & IOS_HW_MASK[idx[4:0]]);
        end
        return v;
    endfunction

    // address decode for the two byte paths and the bit path
    always_comb begin
        ds_ofs   = ds_addr - IOS_DS_OFFSET;
        ds_in    = (ds_addr >= IOS_DS_OFFSET) && (ds_addr <= IOS_DS_TOP);
        wr_go    = io_wr || (data_space_store && ds_in);
        rd_go    = io_rd || (data_space_load && ds_in);
        wr_idx   = io_wr ? io_addr : ds_ofs[5:0];
        rd_idx   = io_rd ? io_addr : ds_ofs[5:0];
        bit_go   = (set_single_io_bit || clear_single_io_bit)
                   && (io_addr <= IOS_BIT_TOP);
        sel_mask = 8'h01 << bit_sel;
    end

    // next state: one byte write or one bit operation per cycle, byte write first
    always_comb begin
        st_next         = st_reg;
        test_byte       = rd_view(io_addr, st_reg.regs, hw_val); // byte under bit test
        st_next.rvalid  = 1'b0;
        st_next.tvalid  = 1'b0;
        st_next.tx_load = 1'b0;
        if (wr_go) begin
            // reserved slots and read-only bits keep their value
            if (!wr_idx[5] && IOS_IMPL[wr_idx[4:0]]) begin
                st_next.regs[wr_idx[4:0]] =
                    ((st_reg.regs[wr_idx[4:0]] & ~IOS_WR_MASK[wr_idx[4:0]])
                     | (wr_data & IOS_WR_MASK[wr_idx[4:0]]))
                    & ~(wr_data & IOS_W1C_MASK[wr_idx[4:0]]);
                st_next.tx_load = (wr_idx[4:0] == IOS_OFS_SERIAL_DATA_BUFFER);
            end
        end else if (bit_go) begin
            // touch only the selected bit; a set on a flag clears it
            if (set_single_io_bit) begin
                st_next.regs[io_addr[4:0]] =
                    (st_reg.regs[io_addr[4:0]] | (sel_mask & IOS_WR_MASK[io_addr[4:0]]))
                    & ~(sel_mask & IOS_W1C_MASK[io_addr[4:0]]);
            end else begin
                st_next.regs[io_addr[4:0]] =
                    st_reg.regs[io_addr[4:0]]
                    & ~(sel_mask & IOS_WR_MASK[io_addr[4:0]]);
            end
            st_next.tx_load = IOS_W1C_MASK[io_addr[4:0]] == 8'h00
                              && io_addr[4:0] == IOS_OFS_SERIAL_DATA_BUFFER;
        end
        // hardware events are applied last so a set beats a same-cycle clear
        for (int i = 0; i < IOS_NREG; i++) begin
            st_next.regs[i] = st_next.regs[i] | (hw_set[i] & IOS_W1C_MASK[i]);
        end
        // reads return the value before this cycle's write
        if (rd_go) begin
            st_next.rdata  = rd_view(rd_idx, st_reg.regs, hw_val);
            st_next.rvalid = 1'b1;
        end
        // bit test: out-of-range addresses answer with no skip
        if (skip_if_io_bit_one || skip_if_io_bit_zero) begin
            st_next.tvalid = 1'b1;
            st_next.skip   = 1'b0;
            if (io_addr <= IOS_BIT_TOP) begin
                st_next.skip = test_byte[bit_sel] == skip_if_io_bit_one;
            end
        end
    end

    // state register; every register holds its reset value until the core writes or a hardware event sets one of its flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.regs    <= {IOS_NREG{IOS_RST_VAL}};
            st_reg.rdata   <= 8'h00;
            st_reg.rvalid  <= 1'b0;
            st_reg.skip    <= 1'b0;
            st_reg.tvalid  <= 1'b0;
            st_reg.tx_load <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register: registered answers and register file
    assign rd_data                = st_reg.rdata;
    assign rd_valid               = st_reg.rvalid;
    assign skip_next              = st_reg.skip;
    assign test_valid             = st_reg.tvalid;
    assign port_b_drive           = st_reg.regs[IOS_OFS_PORT_B_OUTPUT];
    assign port_b_dir             = st_reg.regs[IOS_OFS_PORT_B_DIRECTION];
    assign port_d_drive           = st_reg.regs[IOS_OFS_PORT_D_OUTPUT];
    assign port_d_dir             = st_reg.regs[IOS_OFS_PORT_D_DIRECTION];
    assign comparator_ctrl        = st_reg.regs[IOS_OFS_COMPARATOR_CONTROL_STATUS];
    assign comparator_dig_disable = st_reg.regs[IOS_OFS_COMPARATOR_INPUT_DIGITAL_DISABLE];
    assign serial_enable_ctrl     = st_reg.regs[IOS_OFS_SERIAL_ENABLE_CONTROL];
    assign serial_frame_ctrl      = st_reg.regs[IOS_OFS_SERIAL_FRAME_CONTROL];
    assign serial_baud_divisor    = {st_reg.regs[IOS_OFS_SERIAL_BAUD_DIVISOR_HIGH][3:0],
                                     st_reg.regs[IOS_OFS_SERIAL_BAUD_DIVISOR_LOW]};
    assign serial_tx_data         = st_reg.regs[IOS_OFS_SERIAL_DATA_BUFFER];
    assign serial_tx_load         = st_reg.tx_load;
    assign usi_shift_data         = st_reg.regs[IOS_OFS_UNIVERSAL_SERIAL_SHIFT_DATA];
    assign usi_status             = st_reg.regs[IOS_OFS_UNIVERSAL_SERIAL_STATUS];

    // checks on the register file and answers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    bit_only_a: assert property (
        ce && bit_go && !wr_go && hw_quiet
        |-> ((st_next.regs[io_addr[4:0]] ^ st_reg.regs[io_addr[4:0]]) & ~sel_mask) == 8'h00)
        else $error("bit operation changed another bit");

    bit_range_a: assert property (
        ce && (set_single_io_bit || clear_single_io_bit) && io_addr[5] && !wr_go
        && hw_quiet |=> st_reg.regs == $past(st_reg.regs))
        else $error("bit operation above bit range changed state");

    bit_set_a: assert property (
        ce && set_single_io_bit && !wr_go && io_addr == 6'h18
        |=> port_b_drive[$past(bit_sel)])
        else $error("bit set did not set the port bit");

    w1c_zero_a: assert property (
        ce && io_wr && io_addr == 6'h08 && !wr_data[4] && !comparator_flag_event
        |-> st_next.regs[IOS_OFS_COMPARATOR_CONTROL_STATUS][IOS_CMP_FLAG_BIT]
            == st_reg.regs[IOS_OFS_COMPARATOR_CONTROL_STATUS][IOS_CMP_FLAG_BIT])
        else $error("writing zero changed a flag");

    w1c_one_a: assert property (
        ce && io_wr && io_addr == 6'h08 && wr_data[4] && !comparator_flag_event
        |=> !comparator_ctrl[4])
        else $error("writing one did not clear the flag");

    set_wins_a: assert property (
        ce && comparator_flag_event |=> comparator_ctrl[4])
        else $error("flag event lost");

    skip_test_a: assert property (
        ce && skip_if_io_bit_one && !skip_if_io_bit_zero && !wr_go && !bit_go
        && io_addr == 6'h17 ##1 ce
        |-> test_valid && skip_next == port_b_dir[$past(bit_sel)])
        else $error("bit test gave wrong skip");

    reserved_rd_a: assert property (
        ce && io_rd && io_addr == 6'h05 |=> rd_valid && rd_data == 8'h00)
        else $error("reserved location read nonzero");

    alias_wr_a: assert property (
        ce && data_space_store && !io_wr && ds_addr == 8'h32
        |=> port_d_drive == ($past(wr_data) & 8'h7f))
        else $error("data-space store missed its register");

    io_wr_a: assert property (
        ce && io_wr && io_addr == 6'h13 ##1 ce && !wr_go && !bit_go
        ##1 ce && rd_go && rd_idx == 6'h13 |=> rd_data == $past(wr_data, 3))
        else $error("i/o write then read mismatch");

    freeze_a: assert property (
        !ce |=> st_reg == $past(st_reg))
        else $error("state moved with clock enable low");

    // answer pulses, alias window and register images
    alias_rd_a: assert property (
        ce && data_space_load && !io_rd && ds_addr == 8'h33
        |=> rd_valid && rd_data == $past(st_reg.regs[IOS_OFS_GENERAL_SCRATCH_ZERO]))
        else $error("alias load wrong");

    ds_out_a: assert property (
        ce && data_space_load && !io_rd && !ds_in |=> !rd_valid)
        else $error("load outside alias answered");

    tx_load_a: assert property (
        ce && io_wr && io_addr == 6'h0c |=> serial_tx_load)
        else $error("no transmit load pulse");

    rd_pulse_a: assert property (
        ce && !rd_go |=> !rd_valid)
        else $error("read valid without read");

    bit_clr_a: assert property (
        ce && clear_single_io_bit && !set_single_io_bit && !wr_go && io_addr == 6'h13
        |=> !st_reg.regs[IOS_OFS_GENERAL_SCRATCH_ZERO][$past(bit_sel)])
        else $error("bit clear failed");

    skip_range_a: assert property (
        ce && (skip_if_io_bit_one || skip_if_io_bit_zero) && io_addr[5]
        |=> test_valid && !skip_next)
        else $error("skip above bit range");

    dir_img_a: assert property (
        ce && io_wr && io_addr == 6'h11 |=> port_d_dir == ($past(wr_data) & 8'h7f))
        else $error("direction write lost");

    rsvd_bit_a: assert property (
        ce && io_rd && io_addr == 6'h11 |=> !rd_data[7])
        else $error("reserved bit read nonzero");

    bit_cov_c:   cover property (ce && bit_go && set_single_io_bit);
    skip_cov_c:  cover property (ce && test_valid && skip_next);
    w1c_cov_c:   cover property (ce && io_wr && io_addr == 6'h0e && wr_data[7]);
    store_cov_c: cover property (ce && data_space_store && ds_in);
    load_cov_c:  cover property (ce && data_space_load && ds_in);

endmodule // ios_decoder

// File: logic/ios_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ios_pin_sync
    import ios_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // pins and filtered result
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_q
);

    ios_sync_s st_reg;
    ios_sync_s st_next;
    logic [7:0] agree;

    // a bit only moves once the second and third stage hold the same level
    always_comb begin
        st_next    = st_reg;
        agree      = ~(st_reg.s2 ^ st_reg.s3);
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q  = (st_reg.q & ~agree) | (st_reg.s3 & agree);
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign pin_q = st_reg.q;

endmodule // ios_pin_sync

// File: verif/io_register_space_decoder_bench.sv
// self-checking bench for the low i/o register space decoder
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module io_register_space_decoder_bench
    import ios_pkg::*;
;
    logic       clk, rst_n, ce, cmp_out, cmp_evt, rx_b8, tx_evt, coll, st_evt, ov_evt, sp_evt;
    logic [7:0] stat_in, pa, pb, pd, q;
    logic       v;
    wire        io_rd, io_wr, dl, dst, sb, cb, s1, s0, rv, tv, sk;
    wire  [5:0] ioa;
    wire  [7:0] dsa, wd, rdd, pbd;
    wire  [2:0] bs;
    wire [11:0] baud;
    int         n_mismatch = 0;
    int         compares = 0;
    // live status expected once the live status inputs and pins a and d are high, pin b shows 0x5a and no flag event is raised
    localparam logic [7:0] LIVE_A [7] = '{8'h08, 8'h0a, 8'h0b, 8'h0e, 8'h10, 8'h16, 8'h19};
    localparam logic [7:0] LIVE_E [7] = '{8'h20, 8'h02, 8'hbc, 8'h10, 8'h7f, 8'h5a, 8'h07};

    ios_decoder DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .io_rd(io_rd), .io_wr(io_wr),
        .io_addr(ioa), .data_space_load(dl), .data_space_store(dst), .ds_addr(dsa),
        .set_single_io_bit(sb), .clear_single_io_bit(cb), .skip_if_io_bit_one(s1),
        .skip_if_io_bit_zero(s0), .bit_sel(bs), .wr_data(wd), .rd_data(rdd), .rd_valid(rv),
        .skip_next(sk), .test_valid(tv), .comparator_output(cmp_out),
        .comparator_flag_event(cmp_evt), .serial_status_in(stat_in), .serial_rx_bit8(rx_b8),
        .serial_tx_done_event(tx_evt), .usi_collision(coll), .usi_start_event(st_evt),
        .usi_overflow_event(ov_evt), .usi_stop_event(sp_evt), .pin_a_in(pa), .pin_b_in(pb),
        .pin_d_in(pd), .port_b_drive(pbd), .port_b_dir(), .port_d_drive(), .port_d_dir(),
        .comparator_ctrl(), .comparator_dig_disable(), .serial_enable_ctrl(),
        .serial_frame_ctrl(), .serial_baud_divisor(baud), .serial_tx_data(),
        .serial_tx_load(), .usi_shift_data(), .usi_status());

    ios_core_model core (.clk(clk), .rd_data(rdd), .rd_valid(rv), .skip_next(sk),
        .test_valid(tv), .io_rd(io_rd), .io_wr(io_wr), .io_addr(ioa), .data_space_load(dl),
        .data_space_store(dst), .ds_addr(dsa), .set_single_io_bit(sb),
        .clear_single_io_bit(cb), .skip_if_io_bit_one(s1), .skip_if_io_bit_zero(s0),
        .bit_sel(bs), .wr_data(wd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wr(input int k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
        core.op(k, a, b, d, q, v);
    endtask

    // read or test, answer must be flagged valid and carry the expected value
    task automatic chk_op(input int k, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] exp);
        core.op(k, a, b, 8'h00, q, v);
        `CHK(v, 1'b1)
        `CHK(q, exp)
    endtask

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {rst_n, cmp_out, cmp_evt, rx_b8, tx_evt, coll, st_evt, ov_evt, sp_evt} = '0;
        {stat_in, pa, pb, pd} = '0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (int a = 0; a < 64; a++) chk_op(0, a[7:0], 3'd0, 8'h00);
        // every location read both ways; only implemented slots written, writable bits only
        for (int a = 0; a < 64; a++) begin
            if (a < 32 && IOS_IMPL[a]) wr(1, a[7:0], 3'd0, IOS_WR_MASK[a]);
            chk_op(2, a[7:0] + 8'h20, 3'd0, (a < 32) ? IOS_WR_MASK[a] : 8'h00);
            if (a < 32 && IOS_IMPL[a]) wr(3, a[7:0] + 8'h20, 3'd0, 8'h00);
            chk_op(0, a[7:0], 3'd0, 8'h00);
        end
        core.op(2, 8'h1f, 3'd0, 8'h00, q, v);
        `CHK(v, 1'b0)
        core.op(2, 8'h60, 3'd0, 8'h00, q, v);
        `CHK(v, 1'b0)
        // bit set and clear, with refused ones at the 0x20 alias of the same slot
        wr(1, 8'h13, 3'd0, 8'ha5);
        wr(4, 8'h13, 3'd1, 8'h00);
        wr(5, 8'h13, 3'd7, 8'h00);
        wr(4, 8'h33, 3'd3, 8'h00);
        wr(5, 8'h33, 3'd0, 8'h00);
        chk_op(0, 8'h13, 3'd0, 8'h27);
        chk_op(6, 8'h13, 3'd0, 8'h01);
        chk_op(6, 8'h13, 3'd3, 8'h00);
        chk_op(7, 8'h13, 3'd3, 8'h01);
        chk_op(7, 8'h13, 3'd5, 8'h00);
        chk_op(7, 8'h33, 3'd3, 8'h00);
        chk_op(6, 8'h17, 3'd2, 8'h00);
        // raise every flag for one cycle
        @(negedge clk) {cmp_evt, tx_evt, st_evt, ov_evt, sp_evt} = '1;
        @(negedge clk) {cmp_evt, tx_evt, st_evt, ov_evt, sp_evt} = '0;
        chk_op(0, 8'h08, 3'd0, 8'h10);
        chk_op(0, 8'h0e, 3'd0, 8'he0);
        wr(1, 8'h08, 3'd0, 8'h03);
        chk_op(0, 8'h08, 3'd0, 8'h13);
        wr(4, 8'h08, 3'd2, 8'h00);
        wr(5, 8'h08, 3'd4, 8'h00);
        chk_op(0, 8'h08, 3'd0, 8'h17);
        wr(1, 8'h08, 3'd0, 8'h10);
        chk_op(0, 8'h08, 3'd0, 8'h00);
        wr(4, 8'h0e, 3'd6, 8'h00);
        chk_op(0, 8'h0e, 3'd0, 8'ha0);
        wr(5, 8'h0b, 3'd6, 8'h00);
        chk_op(0, 8'h0b, 3'd0, 8'h40);
        wr(1, 8'h0b, 3'd0, 8'h40);
        chk_op(0, 8'h0b, 3'd0, 8'h00);
        // register images seen at the peripheral side
        wr(3, 8'h38, 3'd0, 8'h3c);
        `CHK(pbd, 8'h3c)
        wr(1, 8'h02, 3'd0, 8'h0a);
        wr(1, 8'h09, 3'd0, 8'h5c);
        `CHK(baud, 12'ha5c)
        wr(4, 8'h18, 3'd0, 8'h00);
        `CHK(pbd, 8'h3d)
        // a write with the clock enable low is dropped
        @(negedge clk) ce = 1'b0;
        wr(1, 8'h14, 3'd0, 8'h77);
        ce = 1'b1;
        chk_op(0, 8'h14, 3'd0, 8'h00);
        // second reset in mid-run, live inputs change meanwhile
        @(negedge clk) rst_n = 1'b0;
        {cmp_out, rx_b8, coll, stat_in, pa, pb, pd} = {3'b111, 8'hff, 8'hff, 8'h5a, 8'hff};
        @(posedge clk) #1;
        `CHK(pbd, 8'h00)
        @(negedge clk) rst_n = 1'b1;
        repeat (6) @(posedge clk);
        chk_op(0, 8'h13, 3'd0, 8'h00);
        for (int i = 0; i < 7; i++) chk_op(0, LIVE_A[i], 3'd0, LIVE_E[i]);
        give_verdict();
    end
endmodule // io_register_space_decoder_bench

// File: verif/ios_core_model.sv
// behavioural model of the 8-bit core issuing i/o and data-space requests
`timescale 1ns/10ps
module ios_core_model
    import ios_pkg::*;
(
    // clock
    input  wire logic       clk,
    // answers from the decoder
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire logic       skip_next,
    input  wire logic       test_valid,
    // requests
    output logic            io_rd,
    output logic            io_wr,
    output logic      [5:0] io_addr,
    output logic            data_space_load,
    output logic            data_space_store,
    output logic      [7:0] ds_addr,
    output logic            set_single_io_bit,
    output logic            clear_single_io_bit,
    output logic            skip_if_io_bit_one,
    output logic            skip_if_io_bit_zero,
    output logic      [2:0] bit_sel,
    output logic      [7:0] wr_data
);
    // idle at time zero
    initial begin
        {io_rd, io_wr, data_space_load, data_space_store} = '0;
        {set_single_io_bit, clear_single_io_bit} = '0;
        {skip_if_io_bit_one, skip_if_io_bit_zero} = '0;
        {io_addr, ds_addr, bit_sel, wr_data} = '0;
    end

    // kind 0 io read, 1 io write, 2 load, 3 store, 4 bit set, 5 bit clear, 6/7 skip tests
    task automatic op(input int k, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
        @(negedge clk);
        {io_addr, ds_addr, bit_sel, wr_data} <= {a[5:0], a, b, d};
        {io_rd, io_wr, data_space_load, data_space_store} <= {k == 0, k == 1, k == 2, k == 3};
        {set_single_io_bit, clear_single_io_bit} <= {k == 4, k == 5};
        {skip_if_io_bit_one, skip_if_io_bit_zero} <= {k == 6, k == 7};
        // held through the taking edge; the answer pulse stands until the next rising edge
        @(posedge clk);
        @(negedge clk);
        q = (k >= 6) ? {7'h00, skip_next} : rd_data;
        v = (k >= 6) ? test_valid : rd_valid;
        {io_rd, io_wr, data_space_load, data_space_store} <= '0;
        {set_single_io_bit, clear_single_io_bit} <= '0;
        {skip_if_io_bit_one, skip_if_io_bit_zero} <= '0;
        // released lines show the inverse, so decoding without a strobe gets caught
        {io_addr, ds_addr, bit_sel, wr_data} <= {~a[5:0], ~a, ~b, ~d};
    endtask
endmodule // ios_core_model
